/* rtl/tws_pkg.sv */
// Shared constants for the two-wire register slave and its master end.
// Assumes both ends run on one 125 MHz clock with synchronous reset.
package tws_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // Link bit period in ns, and the quarter-period in cycles
  localparam int unsigned BIT_NS = 80;
  localparam int unsigned QTR_CYC = (BIT_NS * CLK_MHZ) / (4 * 1000);
  localparam logic [6:0] ADDR_SERIAL = 7'h36; // 0x6C/0x6D
  localparam logic [6:0] ADDR_SUBLVDS = 7'h10; // 0x20/0x21
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
endpackage : tws_pkg

/* rtl/tws_link_if.sv */
// Two-wire link between the register slave and its bus master.
// Resolves the open-drain data line here from the two enables as a wired-AND.
`timescale 1ns/10ps
interface tws_link_if;
  logic scl; // Two-wire clock, driven by the master only
  logic sda_mst_oe; // Master pulls data line low
  logic sda_slv_oe; // Slave pulls data line low
  logic two_wire_data_line; // Resolved wired-AND level
  assign two_wire_data_line = ~(sda_mst_oe | sda_slv_oe);
  modport slave (input scl, input two_wire_data_line, output sda_slv_oe);
  modport master (output scl, input two_wire_data_line, output sda_mst_oe);
endinterface : tws_link_if

/* rtl/tws_master.sv */
// Two-wire bus master: start, byte out with ack sample, byte in, stop.
// Assumes the user issues one command at a time and waits for done.
`timescale 1ns/10ps
module tws_master
  import tws_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd, // 0 start,1 write,2 read,3 stop
  input wire logic i_cmd_ack, // Ack to send after a read byte
  input wire logic [7:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_nack,
  tws_link_if.master link
);
  typedef enum logic [2:0] {TWM_IDLE, TWM_START, TWM_BIT, TWM_STOP}
    twm_state_t;
  twm_state_t st_reg;
  logic [7:0] sh_reg;
  logic [3:0] bit_reg;
  logic [1:0] ph_reg;
  logic [7:0] tick_reg;
  logic rd_reg, ack_reg, scl_reg, oe_reg;
  logic s1_reg, s2_reg;
  wire tick = (tick_reg == 8'(QTR_CYC - 1));
  wire nine = (bit_reg == 4'h8);
  // Bit to drive: data bits from shifter, ack phase per direction
  wire drv_low = nine ? (rd_reg & ack_reg) : (~rd_reg & ~sh_reg[7]);
  always_ff @(posedge i_ref_clk) s1_reg <= link.two_wire_data_line;
  always_ff @(posedge i_ref_clk) s2_reg <= s1_reg;
  // Quarter-bit tick divider
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || st_reg == TWM_IDLE || tick) tick_reg <= 8'h00;
    else tick_reg <= tick_reg + 8'h01;
  end
  // Phase machine, per bit: phase 0 clock low/drive, 1-2 clock high, 3 low
  always_ff @(posedge i_ref_clk) begin
    o_done <= 1'b0;
    if (!i_rst_n) begin
      st_reg <= TWM_IDLE; scl_reg <= 1'b1; oe_reg <= 1'b0; ph_reg <= 2'd0;
      bit_reg <= 4'h0; sh_reg <= BYTE_RESET; rd_reg <= 1'b0;
      ack_reg <= 1'b0; o_rdata <= BYTE_RESET; o_nack <= 1'b0;
      o_busy <= 1'b0;
    end else unique case (st_reg)
      TWM_IDLE: if (i_cmd_valid) begin
        o_busy <= 1'b1; ph_reg <= 2'd0; bit_reg <= 4'h0;
        sh_reg <= i_wdata; rd_reg <= (i_cmd == 3'd2); ack_reg <= i_cmd_ack;
        st_reg <= (i_cmd == 3'd0) ? TWM_START :
                  (i_cmd == 3'd3) ? TWM_STOP : TWM_BIT;
      end
      // Release data, raise clock, pull data low while high
      TWM_START: if (tick) begin
        ph_reg <= ph_reg + 2'd1;
        unique case (ph_reg)
          2'd0: oe_reg <= 1'b0;
          2'd1: scl_reg <= 1'b1;
          2'd2: oe_reg <= 1'b1;
          2'd3: begin scl_reg <= 1'b0; st_reg <= TWM_IDLE;
            o_busy <= 1'b0; o_done <= 1'b1; end
        endcase
      end
      // Nine clock periods, one bit each, MSB first
      TWM_BIT: if (tick) begin
        ph_reg <= ph_reg + 2'd1;
        unique case (ph_reg)
          2'd0: oe_reg <= drv_low; // Change only while low
          2'd1: scl_reg <= 1'b1;
          2'd2: begin
            if (nine) o_nack <= ~rd_reg & s2_reg;
            else sh_reg <= {sh_reg[6:0], s2_reg};
          end
          2'd3: begin
            scl_reg <= 1'b0;
            if (nine) begin
              oe_reg <= 1'b0; st_reg <= TWM_IDLE; o_busy <= 1'b0;
              o_done <= 1'b1; o_rdata <= sh_reg;
            end else bit_reg <= bit_reg + 4'h1;
          end
        endcase
      end
      // Data low, clock high, then data rises while high
      TWM_STOP: if (tick) begin
        ph_reg <= ph_reg + 2'd1;
        unique case (ph_reg)
          2'd0: oe_reg <= 1'b1;
          2'd1: scl_reg <= 1'b1;
          2'd2: oe_reg <= 1'b0;
          2'd3: begin st_reg <= TWM_IDLE; o_busy <= 1'b0;
            o_done <= 1'b1; end
        endcase
      end
      default: st_reg <= TWM_IDLE;
    endcase
  end
  assign link.scl = scl_reg;
  assign link.sda_mst_oe = oe_reg;
endmodule : tws_master

/* rtl/tws_slave.sv */
// Two-wire register slave: framing, address match, pointer, read/write.
// Assumes link pins are asynchronous; a register store sits on the user
// side, answering o_rd_req with i_rd_data in the next cycle.
`timescale 1ns/10ps
module tws_slave
  import tws_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_if_sublvds, // Static strap: output interface choice
  input wire logic [7:0] i_rd_data,
  output logic o_rd_req,
  output logic [15:0] o_addr,
  output logic [7:0] o_wr_data,
  output logic o_wr_en,
  tws_link_if.slave link
);
  typedef enum logic [2:0] {TWS_IDLE, TWS_DEV, TWS_AHI, TWS_ALO,
    TWS_WDAT, TWS_RDAT} tws_state_t;
  tws_state_t st_reg, st_next;
  logic c1_reg, c2_reg, c3_reg, d1_reg, d2_reg, d3_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic [15:0] ptr_reg;
  logic [6:0] own_reg;
  logic oe_reg, ack_reg, load_reg;
  logic [7:0] tx_reg;
  // Two-flop synchronisers, then a third stage for edge finding
  always_ff @(posedge i_ref_clk) begin
    c1_reg <= link.scl; c2_reg <= c1_reg; c3_reg <= c2_reg;
    d1_reg <= link.two_wire_data_line; d2_reg <= d1_reg; d3_reg <= d2_reg;
  end
  wire scl_rise = c2_reg & ~c3_reg;
  wire scl_fall = ~c2_reg & c3_reg;
  wire start_c = c2_reg & c3_reg & d3_reg & ~d2_reg;
  wire stop_c = c2_reg & c3_reg & ~d3_reg & d2_reg;
  wire ack_slot = (cnt_reg == 4'h8);
  wire byte_in = scl_rise & (cnt_reg == BIT_LAST);
  wire [7:0] got = {sh_reg[6:0], d2_reg};
  wire match = (got[7:1] == own_reg);
  wire rd_dir = (sh_reg[0] == DIR_READ);
  // Read-direction byte to us: fetch first byte on the clock rise of its eighth bit
  wire rd_hit = match & (got[0] == DIR_READ);
  wire ack_end = scl_fall & ack_slot;
  // Next state when a byte's ack slot ends
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      TWS_DEV: st_next = ~ack_reg ? TWS_IDLE :
        (rd_dir ? TWS_RDAT : TWS_AHI);
      TWS_AHI: st_next = TWS_ALO;
      TWS_ALO: st_next = TWS_WDAT;
      TWS_WDAT: st_next = TWS_WDAT;
      TWS_RDAT: st_next = ack_reg ? TWS_RDAT : TWS_IDLE;
      TWS_IDLE: st_next = TWS_IDLE;
    endcase
  end
  // Address strap followed while idle with clock high, interface-dependent
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) own_reg <= ADDR_SERIAL;
    else if (st_reg == TWS_IDLE && !c2_reg)
      own_reg <= own_reg;
    else if (st_reg == TWS_IDLE)
      own_reg <= i_if_sublvds ? ADDR_SUBLVDS : ADDR_SERIAL;
  end
  // Bit counter and shifter: eight bits plus ack, one per period
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || start_c) begin
      // Start's own clock fall wraps this to zero before the first bit
      cnt_reg <= 4'hf; sh_reg <= BYTE_RESET;
    end else if (scl_rise && !ack_slot) begin
      sh_reg <= got;
    end else if (scl_rise) begin
      ack_reg <= ~d2_reg; // Master ack in read
    end else if (ack_end) cnt_reg <= 4'h0;
    else if (scl_fall) cnt_reg <= cnt_reg + 4'h1;
  end
  // Protocol state, pointer and store strobes
  always_ff @(posedge i_ref_clk) begin
    o_wr_en <= 1'b0;
    o_rd_req <= 1'b0;
    load_reg <= o_rd_req;
    if (!i_rst_n) begin
      st_reg <= TWS_IDLE; ptr_reg <= PTR_RESET; o_wr_data <= BYTE_RESET;
    end else if (stop_c) st_reg <= TWS_IDLE;
    else if (start_c) st_reg <= TWS_DEV;
    else begin
      if (byte_in) unique case (st_reg)
        TWS_AHI: ptr_reg[15:8] <= got;
        TWS_ALO: ptr_reg[7:0] <= got;
        TWS_WDAT: o_wr_data <= got;
        TWS_RDAT: ptr_reg <= ptr_reg + 16'h0001;
        default: ;
      endcase
      if (ack_end) begin
        st_reg <= st_next;
        if (st_reg == TWS_WDAT) ptr_reg <= ptr_reg + 16'h0001;
      end
      // Fetch early so the first bit is ready before the clock rises
      if (byte_in && st_reg == TWS_DEV && rd_hit) o_rd_req <= 1'b1;
      if (scl_rise && ack_slot && st_reg == TWS_RDAT && !d2_reg)
        o_rd_req <= 1'b1;
      if (byte_in && st_reg == TWS_WDAT) o_wr_en <= 1'b1;
    end
  end
  // Ack flag for device-address byte, set on its eighth bit
  wire dev_ack = byte_in & (st_reg == TWS_DEV) & match;
  // Data line driver: ack when receiving, data bits when sending
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || start_c || stop_c) oe_reg <= 1'b0;
    else if (dev_ack) oe_reg <= 1'b0;
    else if (scl_fall && cnt_reg == BIT_LAST)
      oe_reg <= (st_reg == TWS_DEV) ? (sh_reg[7:1] == own_reg) :
                (st_reg != TWS_RDAT && st_reg != TWS_IDLE);
    else if (ack_end) // First read bit, else release
      oe_reg <= (st_next == TWS_RDAT) ? ~tx_reg[7] : 1'b0;
    else if (scl_fall && st_reg == TWS_RDAT && !ack_slot)
      oe_reg <= ~tx_reg[3'(3'd6 - cnt_reg[2:0])];
  end
  // Pointer out, read byte held while sending
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_addr <= PTR_RESET; tx_reg <= BYTE_RESET;
    end else begin
      o_addr <= ptr_reg;
      if (load_reg) tx_reg <= i_rd_data;
    end
  end
  assign link.sda_slv_oe = oe_reg; // Never touches the clock
endmodule : tws_slave

/* tb/tws_link_properties.sv */
// Link checker for the two-wire slave and master pair.
// Assumes the interface signals and the shared clock as plain inputs.
`timescale 1ns/10ps
module tws_link_properties (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic sda_mst_oe,
  input wire logic sda_slv_oe,
  input wire logic two_wire_data_line
);
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic sda_d_reg;
  logic scl_d_reg;
  wire frame_edge;
  // Start or stop seen; clock rises counted since then
  assign frame_edge = scl && scl_d_reg && (sda_d_reg != two_wire_data_line);
  assign bit_cnt_next = frame_edge ? 4'h0 :
    (scl && !scl_d_reg && bit_cnt_reg != 4'hf) ? bit_cnt_reg + 4'h1 :
    bit_cnt_reg;
  // Line history and bit counter
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      bit_cnt_reg <= 4'h0;
      sda_d_reg <= 1'b1;
      scl_d_reg <= 1'b1;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      sda_d_reg <= two_wire_data_line;
      scl_d_reg <= scl;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_start;
    scl && $rose(sda_mst_oe);
  endsequence
  sequence s_stop;
    scl && $fell(sda_mst_oe);
  endsequence
  property p_slv_chg;
    $changed(sda_slv_oe) |-> !scl;
  endproperty
  property p_scl_high;
    $rose(scl) |-> scl [*2];
  endproperty
  property p_scl_low;
    $fell(scl) |-> !scl [*2];
  endproperty
  property p_start;
    s_start |-> ##[1:16] !scl;
  endproperty
  property p_stop;
    s_stop |-> !sda_slv_oe ##1 two_wire_data_line;
  endproperty
  property p_one_drv;
    scl |-> !(sda_slv_oe && sda_mst_oe);
  endproperty
  property p_ack_slot;
    scl && $past(scl) && sda_slv_oe && bit_cnt_reg < 4'ha
      |-> bit_cnt_reg == 4'h9;
  endproperty
  property p_slv_quiet;
    bit_cnt_reg == 4'h0 |-> !sda_slv_oe;
  endproperty
  a_slv_chg: assert property (p_slv_chg)
    else $error("slave data changed while clock high");
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase too short");
  a_start: assert property (p_start)
    else $error("no clock after start");
  a_stop: assert property (p_stop)
    else $error("line not idle after stop");
  a_one_drv: assert property (p_one_drv)
    else $error("both ends pull data line");
  a_ack_slot: assert property (p_ack_slot)
    else $error("slave drove outside the ack bit");
  a_slv_quiet: assert property (p_slv_quiet)
    else $error("slave drove before first bit");
endmodule : tws_link_properties

/* tb/two_wire_register_slave_test.sv */
// Bench: master and slave joined by the link, register store on the side.
// Assumes an 8 ns clock and one master command at a time.
`timescale 1ns/10ps
module two_wire_register_slave_test;
  import tws_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cmd_valid = 1'b0;
  logic [2:0] i_cmd = 3'h0;
  logic i_cmd_ack = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic i_if_sublvds = 1'b0;
  logic [7:0] i_rd_data = 8'h00;
  logic o_busy, o_done, o_nack, o_rd_req, o_wr_en;
  logic [7:0] o_rdata, o_wr_data;
  logic [15:0] o_addr;
  logic [7:0] mem [logic [15:0]];
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  tws_link_if link();
  tws_master tws_master_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_cmd_ack(i_cmd_ack),
    .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done),
    .o_rdata(o_rdata), .o_nack(o_nack), .link(link));
  tws_slave tws_slave_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_if_sublvds(i_if_sublvds), .i_rd_data(i_rd_data),
    .o_rd_req(o_rd_req), .o_addr(o_addr), .o_wr_data(o_wr_data),
    .o_wr_en(o_wr_en), .link(link));
  tws_link_properties tws_link_properties_i (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .scl(link.scl), .sda_mst_oe(link.sda_mst_oe),
    .sda_slv_oe(link.sda_slv_oe),
    .two_wire_data_line(link.two_wire_data_line));
  always #4 i_ref_clk = ~i_ref_clk;
  // Unwritten store locations read back as a pattern of the address
  function automatic logic [7:0] fill(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : fill
  function automatic logic [7:0] own(input logic s, input logic dir);
    return {s ? ADDR_SUBLVDS : ADDR_SERIAL, dir};
  endfunction : own
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register store, one cycle read latency; cycle ceiling
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    i_rd_data <= mem.exists(o_addr) ? mem[o_addr] : fill(o_addr);
    if (o_wr_en === 1'b1) mem[o_addr] = o_wr_data;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic cmd(input logic [2:0] c, input logic [7:0] d, input logic a);
    int k;
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= c;
    i_wdata <= d;
    i_cmd_ack <= a;
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge i_ref_clk);
      #1;
      if (o_done === 1'b1) break;
    end
    chk({15'h0000, o_done}, 16'h0001);
    chk({15'h0000, o_busy}, 16'h0000);
  endtask : cmd
  task automatic wr(input logic [7:0] d, input logic nk);
    cmd(3'h1, d, 1'b0);
    chk({15'h0000, o_nack}, {15'h0000, nk});
  endtask : wr
  task automatic rd(input logic a, input logic [7:0] e);
    cmd(3'h2, 8'h00, a);
    chk({8'h00, o_rdata}, {8'h00, e});
  endtask : rd
  task automatic seta(input logic [15:0] a);
    cmd(3'h0, 8'h00, 1'b0);
    wr(own(i_if_sublvds, DIR_WRITE), 1'b0);
    wr(a[15:8], 1'b0);
    wr(a[7:0], 1'b0);
  endtask : seta
  // Main sequence
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    chk(o_addr, PTR_RESET);
    seta(16'h12fe);
    wr(8'hff, 1'b0);
    wr(8'h00, 1'b0);
    wr(8'ha5, 1'b0);
    cmd(3'h3, 8'h00, 1'b0);
    chk({8'h00, mem[16'h12fe]}, 16'h00ff);
    chk({8'h00, mem[16'h1300]}, 16'h00a5);
    chk(o_addr, 16'h1301);
    seta(16'h12ff);
    cmd(3'h0, 8'h00, 1'b0);
    wr(own(1'b0, DIR_READ), 1'b0);
    rd(1'b0, 8'h00);
    cmd(3'h3, 8'h00, 1'b0);
    cmd(3'h0, 8'h00, 1'b0);
    wr(own(1'b0, DIR_READ), 1'b0);
    rd(1'b1, 8'ha5);
    rd(1'b1, fill(16'h1301));
    rd(1'b0, fill(16'h1302));
    cmd(3'h3, 8'h00, 1'b0);
    cmd(3'h0, 8'h00, 1'b0);
    wr(own(1'b0, DIR_READ), 1'b0);
    rd(1'b0, fill(16'h1303));
    cmd(3'h3, 8'h00, 1'b0);
    for (int s = 0; s < 2; s++) begin
      @(posedge i_ref_clk);
      i_if_sublvds <= s[0];
      repeat (4) @(posedge i_ref_clk);
      cmd(3'h0, 8'h00, 1'b0);
      wr(own(~s[0], DIR_WRITE), 1'b1);
      cmd(3'h3, 8'h00, 1'b0);
      seta(16'h0040);
      wr(s[0] ? 8'h3c : 8'hc3, 1'b0);
      cmd(3'h3, 8'h00, 1'b0);
      chk({8'h00, mem[16'h0040]}, s[0] ? 16'h003c : 16'h00c3);
    end
    results();
  end
endmodule : two_wire_register_slave_test
